// *** core/mtm_pkg.sv ***
// Package of register map, field positions, reset values and encodings for the modulo timer
package mtm_pkg;
  // Register offsets (plain port address, byte wide registers)
  localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_CLOCK_CONFIG = 2'h1;
  localparam logic [1:0] ADDR_COUNT_VALUE = 2'h2;
  localparam logic [1:0] ADDR_MODULO_VALUE = 2'h3;
  // Status/control field positions
  localparam int SC_OVF_BIT = 7;
  localparam int SC_IRQ_EN_BIT = 6;
  localparam int SC_CLR_BIT = 5;
  localparam int SC_HALT_BIT = 4;
  // Clock configuration field positions
  localparam int CK_SRC_LSB = 4;
  localparam int CK_PS_LSB = 0;
  // Reset values
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] MODULO_RST = 8'h00;
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [3:0] PS_RST = 4'h0;
  localparam logic HALT_RST = 1'b1;
  // Highest documented prescale code
  localparam logic [3:0] PS_MAX = 4'h8;
  // Clock source encodings
  typedef enum logic [1:0]
  {
    MTM_SRC_BUS = 2'h0,
    MTM_SRC_FIXED = 2'h1,
    MTM_SRC_PIN_FALL = 2'h2,
    MTM_SRC_PIN_RISE = 2'h3
  } mtm_src_t;
endpackage

// *** core/mtm_sync.sv ***
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module mtm_sync
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;

  // First stage is read only by the second
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_r <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// *** core/mtm_timer.sv ***
// Eight bit modulo timer with register port, clock selector and prescaler
`timescale 1ns/1ps
// Behaviour
// - Overflow flag sets on wrap past modulo
// - Flag clears by read then zero write
// - Clear bit or modulo write clears flag
// - Interrupt while flag and enable set
// - Clear bit zeroes counter, reads zero
// - Halt bit holds counter value
// - Reset sets the halt bit
// - Source field selects prescaler input clock
// - Source change keeps present count
// - Reset selects bus clock source
// - Prescale field divides by one to 256
// - Prescale change keeps present count
// - Reset selects divide by one
// - Count register read only, resets zero
// - Modulo readable, zero means free running
// - Modulo write zeroes counter, clears flag
// - Reset clears modulo to zero
// - Count up to modulo, then wrap
// - Overflow between steps aborts flag clear
// - Pin clock synchronised before edge detect
// - Debug mode suspends counting
module mtm_timer
(
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic [1:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic FIXED_CLK_I,
  input wire logic EXT_CLK_I,
  input wire logic DEBUG_HALT_I,
  output logic IRQ_O
);
  logic [7:0] count_r;
  logic [7:0] modulo_r;
  logic ovf_r;
  logic irq_en_r;
  logic halt_r;
  logic [1:0] src_r;
  logic [3:0] ps_r;
  logic clr_armed_r;
  logic [7:0] pre_r;
  logic fixed_s;
  logic ext_s;
  logic fixed_d_r;
  logic ext_d_r;
  logic src_tick;
  logic tick;
  logic wrap;
  logic run;
  logic wr_sc;
  logic wr_ck;
  logic wr_mod;
  logic cnt_clear;
  logic [7:0] pre_nxt;
  logic [7:0] rdata_nxt;

  // Synchronise the slow clock and pin inputs
  // pin sync first
  mtm_sync u_sync_ext
  (
    .clk_i(SYS_CLK_I),
    .rst_b_i(RST_B_I),
    .d_i(EXT_CLK_I),
    .q_o(ext_s)
  );

  mtm_sync u_sync_fixed
  (
    .clk_i(SYS_CLK_I),
    .rst_b_i(RST_B_I),
    .d_i(FIXED_CLK_I),
    .q_o(fixed_s)
  );

  // Delayed copies for edge detection
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      fixed_d_r <= 1'b0;
      ext_d_r <= 1'b0;
    end
    else
    begin
      fixed_d_r <= fixed_s;
      ext_d_r <= ext_s;
    end
  end

  // Write decode
  assign wr_sc = WR_I && (ADDR_I == mtm_pkg::ADDR_STATUS_CONTROL);
  assign wr_ck = WR_I && (ADDR_I == mtm_pkg::ADDR_CLOCK_CONFIG);
  assign wr_mod = WR_I && (ADDR_I == mtm_pkg::ADDR_MODULO_VALUE);
  assign cnt_clear = (wr_sc && WDATA_I[mtm_pkg::SC_CLR_BIT]) || wr_mod;

  // Source selection of the prescaler input
  always_comb
  begin
    case (mtm_pkg::mtm_src_t'(src_r))
      mtm_pkg::MTM_SRC_BUS: src_tick = 1'b1;
      mtm_pkg::MTM_SRC_FIXED: src_tick = fixed_s && !fixed_d_r;
      mtm_pkg::MTM_SRC_PIN_FALL: src_tick = !ext_s && ext_d_r;
      default: src_tick = ext_s && !ext_d_r;
    endcase
  end

  assign run = !halt_r && !DEBUG_HALT_I;
  assign pre_nxt = pre_r + 8'h01;

  // Prescaler tap selection
  always_comb
  begin
    tick = 1'b0;
    if (run && src_tick)
    begin
      if (ps_r == 4'h0)
      begin
        tick = 1'b1;
      end
      else if (ps_r >= mtm_pkg::PS_MAX)
      begin
        tick = (pre_r == 8'hff);
      end
      else
      begin
        tick = ((pre_r | ~((8'h01 << ps_r) - 8'h01)) == 8'hff);
      end
    end
  end

  // Prescaler count, cleared by the clear bit or a modulo write but not by a wrap; not cleared by config changes
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      pre_r <= 8'h00;
    end
    else if (cnt_clear)
    begin
      pre_r <= 8'h00;
    end
    else if (run && src_tick)
    begin
      pre_r <= pre_nxt;
    end
  end

  assign wrap = tick && ((modulo_r == 8'h00) ? (count_r == 8'hff) : (count_r == modulo_r));

  // Main counter
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      count_r <= mtm_pkg::COUNT_RST;
    end
    else if (cnt_clear || wrap)
    begin
      count_r <= 8'h00;
    end
    else if (tick)
    begin
      count_r <= count_r + 8'h01;
    end
  end

  // Clear sequence arming: read with flag set, lost on a new overflow
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      clr_armed_r <= 1'b0;
    end
    else if (wrap || cnt_clear)
    begin
      clr_armed_r <= 1'b0;
    end
    else if (RD_I && ADDR_I == mtm_pkg::ADDR_STATUS_CONTROL && ovf_r)
    begin
      clr_armed_r <= 1'b1;
    end
    else if (wr_sc)
    begin
      clr_armed_r <= 1'b0;
    end
  end

  // Overflow flag; a wrap beats the two-step clear, a counter reset beats both
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ovf_r <= 1'b0;
    end
    else if (wrap && !cnt_clear)
    begin
      ovf_r <= 1'b1;
    end
    else if (cnt_clear)
    begin
      ovf_r <= 1'b0;
    end
    else if (wr_sc && clr_armed_r && !WDATA_I[mtm_pkg::SC_OVF_BIT])
    begin
      ovf_r <= 1'b0;
    end
  end

  // Status/control writable bits
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      irq_en_r <= 1'b0;
      halt_r <= mtm_pkg::HALT_RST;
    end
    else if (wr_sc)
    begin
      irq_en_r <= WDATA_I[mtm_pkg::SC_IRQ_EN_BIT];
      halt_r <= WDATA_I[mtm_pkg::SC_HALT_BIT];
    end
  end

  // Clock configuration fields
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      src_r <= mtm_pkg::SRC_RST;
      ps_r <= mtm_pkg::PS_RST;
    end
    else if (wr_ck)
    begin
      src_r <= WDATA_I[mtm_pkg::CK_SRC_LSB +: 2];
      ps_r <= WDATA_I[mtm_pkg::CK_PS_LSB +: 4];
    end
  end

  // Modulo register
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      modulo_r <= mtm_pkg::MODULO_RST;
    end
    else if (wr_mod)
    begin
      modulo_r <= WDATA_I;
    end
  end

  // Read multiplexer
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (ADDR_I == mtm_pkg::ADDR_STATUS_CONTROL)
    begin
      rdata_nxt[mtm_pkg::SC_OVF_BIT] = ovf_r;
      rdata_nxt[mtm_pkg::SC_IRQ_EN_BIT] = irq_en_r;
      rdata_nxt[mtm_pkg::SC_HALT_BIT] = halt_r;
    end
    else if (ADDR_I == mtm_pkg::ADDR_CLOCK_CONFIG)
    begin
      rdata_nxt[mtm_pkg::CK_SRC_LSB +: 2] = src_r;
      rdata_nxt[mtm_pkg::CK_PS_LSB +: 4] = ps_r;
    end
    else if (ADDR_I == mtm_pkg::ADDR_COUNT_VALUE)
    begin
      rdata_nxt = count_r;
    end
    else
    begin
      rdata_nxt = modulo_r;
    end
  end

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      RDATA_O <= 8'h00;
    end
    else
    begin
      RDATA_O <= RD_I ? rdata_nxt : 8'h00;
    end
  end

  assign IRQ_O = ovf_r && irq_en_r;

  // Assertions
  wrap_sets_flag_a:
    assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (wrap && !cnt_clear) |=> ovf_r)
    else $error("overflow flag not set on wrap");
  flag_by_wrap_a:
    assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      $rose(ovf_r) |-> $past(wrap))
    else $error("overflow flag set without a wrap");
  clear_needs_arm_a:
    assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      ($fell(ovf_r) && !$past(cnt_clear)) |-> $past(clr_armed_r && wr_sc))
    else $error("flag cleared without read then write");
  modwr_clears_a:
    assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      wr_mod |=> (count_r == 8'h00 && !ovf_r))
    else $error("modulo write did not clear count and flag");
  clrbit_clears_a:
    assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (wr_sc && WDATA_I[mtm_pkg::SC_CLR_BIT]) |=> (count_r == 8'h00 && !ovf_r))
    else $error("clear bit did not clear");
  halt_holds_a:
    assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (halt_r && !cnt_clear) |=> $stable(count_r))
    else $error("count moved while halted");
  irq_level_a:
    assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      IRQ_O == (ovf_r && irq_en_r) && (!$rose(IRQ_O) || $past(wrap || wr_sc)))
    else $error("interrupt request mismatch");
  count_step_a:
    assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (tick && !wrap && !cnt_clear) |=> count_r == $past(count_r) + 8'h01)
    else $error("count did not step by one");
  debug_hold_a:
    assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (DEBUG_HALT_I && !cnt_clear) |=> $stable(count_r))
    else $error("count moved in debug");
  sc_read_zero_a:
    assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
      (RD_I && ADDR_I == mtm_pkg::ADDR_STATUS_CONTROL) |=> (RDATA_O & 8'h2f) == 8'h00)
    else $error("unassigned status bits nonzero");
  wrap_c: cover property (@(posedge SYS_CLK_I) disable iff (!RST_B_I) wrap && modulo_r != 8'h00);
  clear_seq_c: cover property (@(posedge SYS_CLK_I) disable iff (!RST_B_I) $fell(ovf_r));
  irq_c: cover property (@(posedge SYS_CLK_I) disable iff (!RST_B_I) $rose(IRQ_O));
endmodule

// *** bench/tb_mtm_timer.sv ***
// Self-checking bench for the modulo timer: registers, prescaler, sources, flag and irq
`timescale 1ns/1ps
module tb_mtm_timer;
  localparam logic [1:0] A_SC = mtm_pkg::ADDR_STATUS_CONTROL;
  localparam logic [1:0] A_CK = mtm_pkg::ADDR_CLOCK_CONFIG;
  localparam logic [1:0] A_CNT = mtm_pkg::ADDR_COUNT_VALUE;
  localparam logic [1:0] A_MOD = mtm_pkg::ADDR_MODULO_VALUE;
  logic clk, rst_b, wr, rd, fclk, eclk, dbg, irq;
  logic [1:0] addr;
  logic [3:0] p;
  logic [7:0] wdata, rdata, v, m, r;
  int fail_count, num_checks, cyc, k, n, e;

  mtm_timer u_mtm_timer (.SYS_CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .FIXED_CLK_I(fclk), .EXT_CLK_I(eclk),
    .DEBUG_HALT_I(dbg), .IRQ_O(irq));

  // Verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Expected count after a number of source ticks at one prescale code
  function automatic int exp_count(input logic [3:0] ps, input int ticks);
    return ticks >> ((ps > mtm_pkg::PS_MAX) ? 8 : int'(ps));
  endfunction

  // Exact compare
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
    num_checks++;
    if (g !== ex)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, g);
    end
  endtask

  // Range compare, an unknown never passes
  task automatic rng(input string nm, input int lo, input int hi, input logic [7:0] g);
    num_checks++;
    if (($signed({1'b0, g}) >= lo && $signed({1'b0, g}) <= hi) !== 1'b1)
    begin
      fail_count++;
      $display("mismatch %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rchk(input string nm, input logic [1:0] a, input logic [7:0] ex);
    logic [7:0] d;
    rd_reg(a, d);
    chk(nm, ex, d);
  endtask

  // Clock source
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    fclk = 1'b0;
    eclk = 1'b0;
    dbg = 1'b0;
    fail_count = 0;
    num_checks = 0;
    cyc = 0;
    v = 8'($urandom(32'h3aa1));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rchk("status reset", A_SC, 8'h10);
    rchk("clock reset", A_CK, 8'h00);
    rchk("count reset", A_CNT, 8'h00);
    rchk("modulo reset", A_MOD, 8'h00);
    wr_reg(A_SC, 8'h3f);
    rchk("status spare", A_SC, 8'h10);
    wr_reg(A_CK, 8'hff);
    rchk("clock spare", A_CK, 8'h3f);
    wr_reg(A_CNT, 8'h5a);
    rchk("count write", A_CNT, 8'h00);
    // Prescale codes 0 to 8 and 15, source change while running, then hold
    for (k = 0; k < 10; k++)
    begin
      p = (k == 9) ? 4'hf : 4'(k);
      wr_reg(A_CK, {4'h0, p});
      wr_reg(A_SC, 8'h30);
      wr_reg(A_SC, 8'h00);
      repeat (200) @(posedge clk);
      wr_reg(A_CK, {4'h1, p});
      wr_reg(A_CK, {4'h0, p});
      wr_reg(A_SC, 8'h10);
      rd_reg(A_CNT, v);
      // Run spans 204 bus ticks; two edges pass on the quiet fixed source
      e = exp_count(p, 204);
      rng("prescaled count", e - 2, e + 1, v);
      repeat (8) @(posedge clk);
      rchk("held count", A_CNT, v);
    end
    // Debug suspend, at divide by one so a missed suspend shows
    wr_reg(A_CK, 8'h00);
    wr_reg(A_SC, 8'h30);
    dbg <= 1'b1;
    wr_reg(A_SC, 8'h00);
    repeat (20) @(posedge clk);
    wr_reg(A_SC, 8'h10);
    dbg <= 1'b0;
    rchk("debug count", A_CNT, 8'h00);
    // Fixed clock, pin falling and pin rising sources
    for (k = 1; k < 4; k++)
    begin
      n = $urandom_range(20, 1);
      wr_reg(A_CK, 8'(k << 4));
      wr_reg(A_SC, 8'h30);
      wr_reg(A_SC, 8'h00);
      repeat (n)
      begin
        repeat (4) @(posedge clk);
        if (k == 1)
          fclk <= 1'b1;
        else
          eclk <= 1'b1;
        repeat (4) @(posedge clk);
        fclk <= 1'b0;
        eclk <= 1'b0;
      end
      repeat (6) @(posedge clk);
      wr_reg(A_SC, 8'h10);
      rchk("source count", A_CNT, 8'(n));
    end
    // Modulo wrap, flag set and two-step clear
    m = 8'($urandom_range(9, 2));
    wr_reg(A_CK, 8'h00);
    wr_reg(A_MOD, m);
    wr_reg(A_SC, 8'h00);
    repeat (24)
    begin
      rd_reg(A_CNT, v);
      rng("count bound", 0, int'(m), v);
    end
    wr_reg(A_SC, 8'h10);
    rchk("flag set", A_SC, 8'h90);
    wr_reg(A_SC, 8'h10);
    rchk("flag cleared", A_SC, 8'h10);
    wr_reg(A_SC, 8'h00);
    repeat (24) @(posedge clk);
    rchk("flag again", A_SC, 8'h80);
    repeat (12) @(posedge clk);
    wr_reg(A_SC, 8'h10);
    rchk("flag kept", A_SC, 8'h90);
    r = 8'($urandom);
    wr_reg(A_MOD, r);
    rchk("modulo write flag", A_SC, 8'h10);
    rchk("modulo write count", A_CNT, 8'h00);
    rchk("modulo value", A_MOD, r);
    // Interrupt raise, then clear bit
    wr_reg(A_MOD, m);
    wr_reg(A_SC, 8'h50);
    #1;
    chk("irq idle", 8'h00, {7'h0, irq});
    wr_reg(A_SC, 8'h40);
    for (n = 0; n < 40 && irq !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    chk("irq raised", 8'h01, {7'h0, irq});
    wr_reg(A_SC, 8'h70);
    #1;
    chk("irq dropped", 8'h00, {7'h0, irq});
    rchk("clear count", A_CNT, 8'h00);
    rchk("clear status", A_SC, 8'h50);
    report_and_stop();
  end
endmodule
